/* hdl/freq_select_watchdog_recovery.sv */
// frequency source selection, watchdog timer and recovery switch-over
`timescale 1ns/100ps
`default_nettype none
module freq_select_watchdog_recovery
	import freq_watchdog_pkg::*;
#(
	parameter logic [23:0] SHORT_EDGES = 24'(TICK_SHORT_EDGES),
	parameter logic [23:0] LONG_EDGES  = 24'(TICK_LONG_EDGES),
	parameter logic [7:0]  RESET_CYC   = 8'(RESET_PULSE_CYC)
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// pins
	input  wire logic [4:0] strapFreqInputs,
	input  wire logic       refClkPin,
	// register byte port from the bus engine
	input  wire logic       regWrEn,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	output var  logic [7:0] regRdData,
	// frequency to the synthesizer
	output var  logic       outProgrammed,
	output var  logic [4:0] outFreqCode,
	output var  logic [7:0] outNumerator,
	output var  logic [6:0] outDenominator,
	output var  logic       freqLoad,
	output var  logic       recoveryActive,
	// system reset
	output var  logic       sysReset
);

	typedef struct packed {
		logic [4:0]  strapMeta;
		logic [4:0]  strapSync;
		logic [1:0]  settle;
		logic        strapTaken;
		logic [4:0]  latchedStraps;
		logic        progEn;
		logic        strapOverride;
		logic        recoverySourceSelect;
		logic        watchdogEnable;
		logic        watchdogTickScale;
		logic        resetOnExpiryEnable;
		logic        resetOnRetuneEnable;
		logic        watchdogExpiredFlag;
		logic [4:0]  freqCode;
		logic [7:0]  cpuNumerator;
		logic [6:0]  cpuDenominator;
		logic [7:0]  recoveryNumerator;
		logic [6:0]  recoveryDenominator;
		logic [4:0]  watchdogCountLoad;
		wd_state_t   wdState;
		logic [5:0]  wdCount;
		logic        pendingLoad;
		logic        outProgrammed;
		logic [4:0]  outFreqCode;
		logic [7:0]  outNumerator;
		logic [6:0]  outDenominator;
		logic        freqLoad;
		logic [7:0]  resetCount;
		logic        sysReset;
		logic [7:0]  rdData;
	} top_state_t;

	top_state_t s;
	top_state_t next_s;
	logic       tick;
	logic       tgtProgrammed;
	logic [4:0] tgtCode;
	logic [7:0] tgtNum;
	logic [6:0] tgtDen;
	logic       loadNow;
	logic       expireNow;
	logic       clearFlag;
	logic       writeLoad;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// a cpu pair write reloads only while that pair drives the outputs
	function automatic logic cpu_pair_live(input logic en, input logic expired);
		return en && !expired;
	endfunction

	// a recovery pair write reloads only while recovery runs from that pair
	function automatic logic rcv_pair_live(input logic expired, input logic sel);
		return expired && sel;
	endfunction

	// seven-bit denominator shown as a read byte
	function automatic logic [7:0] den_byte(input logic [6:0] den);
		return {1'b0, den};
	endfunction

	// ----------------------------------------------------------------
	// watchdog time base
	// ----------------------------------------------------------------
	ref_tick_gen #(
		.SHORT_EDGES (SHORT_EDGES),
		.LONG_EDGES  (LONG_EDGES)
	) u_tick (
		.core_clk  (core_clk),
		.rst       (rst),
		.refClkPin (refClkPin),
		.run       (s.wdState == WD_COUNTING),
		.longScale (s.watchdogTickScale),
		.tick      (tick)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.freqLoad = 1'b0;
		next_s.pendingLoad = 1'b0;
		clearFlag = 1'b0;
		writeLoad = 1'b0;
		expireNow = 1'b0;

		// strap capture once the synchroniser has filled
		next_s.strapMeta = strapFreqInputs;
		next_s.strapSync = s.strapMeta;
		if (!s.strapTaken) begin
			if (s.settle == 2'(STRAP_SETTLE_CYC)) begin
				next_s.latchedStraps = s.strapSync;
				next_s.strapTaken = 1'b1;
			end else begin
				next_s.settle = s.settle + 2'b01;
			end
		end

		// register writes
		if (regWrEn) begin
			if (regAddr == ADDR_CONTROL) begin
				next_s.progEn = regWrData[CTL_PROG_EN];
				next_s.strapOverride = regWrData[CTL_OVERRIDE];
				next_s.recoverySourceSelect = regWrData[CTL_RCV_SELECT];
				next_s.watchdogEnable = regWrData[CTL_WD_ENABLE];
				next_s.watchdogTickScale = regWrData[CTL_TICK_SCALE];
				next_s.resetOnExpiryEnable = regWrData[CTL_RST_EXPIRY];
				next_s.resetOnRetuneEnable = regWrData[CTL_RST_RETUNE];
				clearFlag = regWrData[CTL_EXPIRED];
			end else if (regAddr == ADDR_FREQ_CODE) begin
				next_s.freqCode = regWrData[4:0];
			end else if (regAddr == ADDR_CPU_NUM) begin
				next_s.cpuNumerator = regWrData;
				writeLoad = cpu_pair_live(s.progEn, s.watchdogExpiredFlag);
			end else if (regAddr == ADDR_CPU_DEN) begin
				next_s.cpuDenominator = regWrData[6:0];
				writeLoad = cpu_pair_live(s.progEn, s.watchdogExpiredFlag);
			end else if (regAddr == ADDR_RCV_NUM) begin
				next_s.recoveryNumerator = regWrData;
				writeLoad = rcv_pair_live(s.watchdogExpiredFlag, s.recoverySourceSelect);
			end else if (regAddr == ADDR_RCV_DEN) begin
				next_s.recoveryDenominator = regWrData[6:0];
				writeLoad = rcv_pair_live(s.watchdogExpiredFlag, s.recoverySourceSelect);
			end else if (regAddr == ADDR_WD_LOAD) begin
				next_s.watchdogCountLoad = regWrData[4:0];
			end
		end
		next_s.pendingLoad = writeLoad;

		// frequency source selection from the present settings
		tgtCode = s.strapOverride ? s.freqCode : s.latchedStraps;
		tgtNum = s.cpuNumerator;
		tgtDen = s.cpuDenominator;
		if (s.watchdogExpiredFlag) begin
			if (s.recoverySourceSelect) begin
				tgtProgrammed = 1'b1;
				tgtNum = s.recoveryNumerator;
				tgtDen = s.recoveryDenominator;
			end else begin
				tgtProgrammed = 1'b0;
				tgtCode = s.latchedStraps;
			end
		end else begin
			tgtProgrammed = s.progEn;
		end
		if (!tgtProgrammed) begin
			tgtNum = s.outNumerator;
			tgtDen = s.outDenominator;
		end

		// any pair is passed on unclipped so the full output span is reachable;
		// outputs keep their reset values until the straps are captured
		if (s.strapTaken) begin
			next_s.outProgrammed = tgtProgrammed;
			next_s.outFreqCode = tgtCode;
			next_s.outNumerator = tgtNum;
			next_s.outDenominator = tgtDen;
		end
		loadNow = s.strapTaken && (s.pendingLoad
			|| tgtProgrammed != s.outProgrammed || tgtCode != s.outFreqCode
			|| tgtNum != s.outNumerator || tgtDen != s.outDenominator);
		next_s.freqLoad = loadNow;

		// watchdog
		case (s.wdState)
			WD_STOPPED: begin
				next_s.wdCount = wd_start_count(s.watchdogCountLoad);
				if (s.watchdogEnable) begin
					next_s.wdState = WD_ARMED;
				end
			end
			WD_ARMED: begin
				next_s.wdCount = wd_start_count(s.watchdogCountLoad);
				if (!s.watchdogEnable) begin
					next_s.wdState = WD_STOPPED;
				end else if (loadNow) begin
					next_s.wdState = WD_COUNTING;
				end
			end
			WD_COUNTING: begin
				if (!s.watchdogEnable) begin
					next_s.wdState = WD_STOPPED;
					next_s.wdCount = wd_start_count(s.watchdogCountLoad);
				end else if (tick) begin
					next_s.wdCount = s.wdCount - 6'h01;
					if (s.wdCount == 6'h01) begin
						next_s.wdState = WD_EXPIRED;
						expireNow = 1'b1;
					end
				end
			end
			WD_EXPIRED: begin
				if (!s.watchdogEnable) begin
					next_s.wdState = WD_STOPPED;
				end else if (!s.watchdogExpiredFlag) begin
					next_s.wdState = WD_ARMED;
				end
			end
			default: begin
				next_s.wdState = WD_STOPPED;
			end
		endcase

		// expired flag: a time-out in the clearing cycle wins
		if (expireNow) begin
			next_s.watchdogExpiredFlag = 1'b1;
		end else if (clearFlag) begin
			next_s.watchdogExpiredFlag = 1'b0;
		end

		// system reset pulse
		if ((expireNow && s.resetOnExpiryEnable) || (loadNow && s.resetOnRetuneEnable)) begin
			next_s.resetCount = RESET_CYC;
			next_s.sysReset = 1'b1;
		end else if (s.resetCount != 8'h00) begin
			next_s.resetCount = s.resetCount - 8'h01;
			next_s.sysReset = (s.resetCount != 8'h01);
		end

		// registered read data
		if (regAddr == ADDR_CONTROL) begin
			next_s.rdData = {s.progEn, s.strapOverride, s.recoverySourceSelect, s.watchdogEnable,
				s.watchdogTickScale, s.resetOnExpiryEnable, s.resetOnRetuneEnable,
				s.watchdogExpiredFlag};
		end else if (regAddr == ADDR_FREQ_CODE) begin
			next_s.rdData = {3'h0, s.freqCode};
		end else if (regAddr == ADDR_CPU_NUM) begin
			next_s.rdData = s.cpuNumerator;
		end else if (regAddr == ADDR_CPU_DEN) begin
			next_s.rdData = den_byte(s.cpuDenominator);
		end else if (regAddr == ADDR_RCV_NUM) begin
			next_s.rdData = s.recoveryNumerator;
		end else if (regAddr == ADDR_RCV_DEN) begin
			next_s.rdData = den_byte(s.recoveryDenominator);
		end else if (regAddr == ADDR_WD_LOAD) begin
			next_s.rdData = {3'h0, s.watchdogCountLoad};
		end else if (regAddr == ADDR_STATUS) begin
			next_s.rdData = {s.strapTaken, s.wdState == WD_COUNTING,
				s.outNumerator > {1'b0, s.outDenominator}, s.latchedStraps};
		end else begin
			next_s.rdData = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s <= '0;
			s.progEn <= PROG_EN_RESET;
			s.strapOverride <= OVERRIDE_RESET;
			s.freqCode <= CODE_RESET;
			s.cpuNumerator <= NUM_RESET;
			s.cpuDenominator <= DEN_RESET;
			s.recoveryNumerator <= NUM_RESET;
			s.recoveryDenominator <= DEN_RESET;
			s.watchdogCountLoad <= WD_LOAD_RESET;
			s.wdState <= WD_STOPPED;
		end else begin
			s <= next_s;
		end
	end

	assign regRdData = s.rdData;
	assign outProgrammed = s.outProgrammed;
	assign outFreqCode = s.outFreqCode;
	assign outNumerator = s.outNumerator;
	assign outDenominator = s.outDenominator;
	assign freqLoad = s.freqLoad;
	assign recoveryActive = s.watchdogExpiredFlag;
	assign sysReset = s.sysReset;

endmodule
`default_nettype wire

/* hdl/freq_watchdog_pkg.sv */
// constants, types and helpers shared by the frequency select and watchdog logic
//
// Operation
// - programmable off: frequency code from latched straps, or software code when override set
// - programmable frequency enable is zero after power-on
// - strap override is zero after power-on, so straps select the frequency
// - programmable on: CPU frequency from 8-bit numerator, 7-bit denominator and gear constant
// - programmable on: gear and ratio from straps, or software code when override set
// - a write to CPU numerator or denominator starts a frequency load while programmable on and not expired
// - time-out switches to recovery: straps when select is 0, recovery pair when 1
// - recovery pair uses ratio from straps, or software code when override set
// - a write to recovery numerator or denominator starts a frequency load while recovery runs from the recovery pair
// - watchdog enable written 0 stops the timer and reloads its time-out value
// - watchdog enabled starts counting down once a frequency change occurs
// - watchdog expiry activates the recovery frequency and may issue a system reset
// - programmable mode passes every numerator and denominator, covering 50 to 248 MHz
// - expired flag reads 1 after time-out; write 1 clears, write 0 ignored
// - 5-bit load value counts ticks of 150 ms or 2.5 s; zero counts 32 ticks
// - reset-on-expiry enabled gives a reset pulse at time-out, otherwise none
// - reset-on-retune enabled gives a reset pulse after every frequency change
package freq_watchdog_pkg;

	// ----------------------------------------------------------------
	// register byte indices
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL   = 8'h00;
	localparam logic [7:0] ADDR_FREQ_CODE = 8'h01;
	localparam logic [7:0] ADDR_CPU_NUM   = 8'h02;
	localparam logic [7:0] ADDR_CPU_DEN   = 8'h03;
	localparam logic [7:0] ADDR_RCV_NUM   = 8'h04;
	localparam logic [7:0] ADDR_RCV_DEN   = 8'h05;
	localparam logic [7:0] ADDR_WD_LOAD   = 8'h06;
	localparam logic [7:0] ADDR_STATUS    = 8'h07;

	// ----------------------------------------------------------------
	// control byte fields
	// ----------------------------------------------------------------
	localparam int CTL_PROG_EN     = 7;
	localparam int CTL_OVERRIDE    = 6;
	localparam int CTL_RCV_SELECT  = 5;
	localparam int CTL_WD_ENABLE   = 4;
	localparam int CTL_TICK_SCALE  = 3;
	localparam int CTL_RST_EXPIRY  = 2;
	localparam int CTL_RST_RETUNE  = 1;
	localparam int CTL_EXPIRED     = 0;

	// status byte fields above the latched strap code
	localparam int STS_RATIO_OK    = 5;
	localparam int STS_COUNTING    = 6;
	localparam int STS_STRAP_TAKEN = 7;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic       PROG_EN_RESET   = 1'b0;
	localparam logic       OVERRIDE_RESET  = 1'b0;
	localparam logic [4:0] CODE_RESET      = 5'h00;
	localparam logic [7:0] NUM_RESET       = 8'h00;
	localparam logic [6:0] DEN_RESET       = 7'h00;
	localparam logic [4:0] WD_LOAD_RESET   = 5'h0f;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int    CORE_PERIOD_NS   = 8;
	localparam int    REF_PERIOD_NS    = 160;
	localparam int    TICK_SHORT_MS    = 150;
	localparam int    TICK_LONG_MS     = 2500;
	localparam int    RESET_PULSE_NS   = 1000;
	localparam longint TICK_SHORT_EDGES = longint'(TICK_SHORT_MS) * 64'd1000000 / REF_PERIOD_NS;
	localparam longint TICK_LONG_EDGES  = longint'(TICK_LONG_MS) * 64'd1000000 / REF_PERIOD_NS;
	localparam int    RESET_PULSE_CYC  = (RESET_PULSE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int    STRAP_SETTLE_CYC = 2;

	// a load value of zero stands for the full 32-tick span
	localparam logic [5:0] WD_FULL_COUNT = 6'h20;

	typedef enum logic [1:0] {
		WD_STOPPED  = 2'b00,
		WD_ARMED    = 2'b01,
		WD_COUNTING = 2'b10,
		WD_EXPIRED  = 2'b11
	} wd_state_t;

	function automatic logic [5:0] wd_start_count(input logic [4:0] load);
		return (load == 5'h00) ? WD_FULL_COUNT : {1'b0, load};
	endfunction

endpackage

/* hdl/ref_tick_gen.sv */
// reference clock sampler and watchdog tick prescaler
`timescale 1ns/100ps
`default_nettype none
module ref_tick_gen
	import freq_watchdog_pkg::*;
#(
	parameter logic [23:0] SHORT_EDGES = 24'(TICK_SHORT_EDGES),
	parameter logic [23:0] LONG_EDGES  = 24'(TICK_LONG_EDGES)
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// reference pin
	input  wire logic refClkPin,
	// control
	input  wire logic run,
	input  wire logic longScale,
	// tick pulse
	output var  logic tick
);

	typedef struct packed {
		logic        refMeta;
		logic        refSync;
		logic        refPrev;
		logic [23:0] edgeCount;
		logic        tick;
	} tick_state_t;

	tick_state_t s;
	tick_state_t next_s;
	logic [23:0] limit;

	always_comb begin
		next_s = s;
		next_s.refMeta = refClkPin;
		next_s.refSync = s.refMeta;
		next_s.refPrev = s.refSync;
		next_s.tick = 1'b0;
		limit = longScale ? LONG_EDGES : SHORT_EDGES;
		if (!run) begin
			next_s.edgeCount = 24'h000000;
		end else if (s.refSync && !s.refPrev) begin
			if (s.edgeCount >= limit - 24'h000001) begin
				next_s.edgeCount = 24'h000000;
				next_s.tick = 1'b1;
			end else begin
				next_s.edgeCount = s.edgeCount + 24'h000001;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule
`default_nettype wire

/* testbench/freq_watchdog_asserts.sv */
// port checker for frequency select and watchdog recovery
`timescale 1ns/100ps
`default_nettype none
module freq_watchdog_asserts
	import freq_watchdog_pkg::*;
#(
	parameter logic [7:0] RESET_CYC = 8'(RESET_PULSE_CYC)
) (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// register port
	input wire logic       regWrEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	// synthesizer side
	input wire logic       outProgrammed,
	input wire logic [4:0] outFreqCode,
	input wire logic [7:0] outNumerator,
	input wire logic [6:0] outDenominator,
	input wire logic       freqLoad,
	input wire logic       recoveryActive,
	input wire logic       sysReset
);
	// ------------------------------------------
	// control shadow and reset pulse counter
	// ------------------------------------------
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] hiCnt;
	} shadow_t;
	shadow_t sh;
	shadow_t next_sh;
	always_comb begin
		next_sh = sh;
		if (regWrEn && regAddr == ADDR_CONTROL)
			next_sh.ctl = regWrData;
		next_sh.hiCnt = sysReset ? sh.hiCnt + 8'h01 : 8'h00;
		if (rst)
			next_sh = '0;
	end
	always_ff @(posedge core_clk) sh <= next_sh;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_cpuWr;
		regWrEn && (regAddr == ADDR_CPU_NUM || regAddr == ADDR_CPU_DEN);
	endsequence
	sequence s_rcvWr;
		regWrEn && (regAddr == ADDR_RCV_NUM || regAddr == ADDR_RCV_DEN);
	endsequence
	sequence s_load2;
		##2 freqLoad;
	endsequence

	a_reset_quiet: assert property (
		$fell(rst) |-> !outProgrammed && outFreqCode == 5'h00 && !sysReset && !recoveryActive
	) else $error("outputs not cleared by reset");
	a_change_with_load: assert property (
		!$stable({outProgrammed, outFreqCode, outNumerator, outDenominator}) |-> ##[0:1] freqLoad
	) else $error("frequency outputs changed without load pulse");
	a_cpu_write_load: assert property (
		s_cpuWr ##0 (sh.ctl[CTL_PROG_EN] && !recoveryActive) |-> s_load2
	) else $error("cpu pair write gave no load");
	a_rcv_write_load: assert property (
		s_rcvWr ##0 (recoveryActive && sh.ctl[CTL_RCV_SELECT]) |-> s_load2
	) else $error("recovery pair write gave no load");
	a_expiry_reset: assert property (
		$rose(recoveryActive) && sh.ctl[CTL_RST_EXPIRY] |-> sysReset
	) else $error("no reset at expiry");
	a_retune_reset: assert property (
		freqLoad && sh.ctl[CTL_RST_RETUNE] |-> sysReset
	) else $error("no reset after frequency change");
	a_reset_cause: assert property (
		$rose(sysReset) |-> (freqLoad && sh.ctl[CTL_RST_RETUNE]) || sh.ctl[CTL_RST_EXPIRY]
	) else $error("reset pulse without enabled cause");
	a_pulse_length: assert property (
		$fell(sysReset) && !$past(rst) |-> sh.hiCnt >= RESET_CYC
	) else $error("reset pulse too short");
	a_expiry_switch: assert property (
		$rose(recoveryActive) |-> ##[1:2] (outProgrammed == sh.ctl[CTL_RCV_SELECT])
	) else $error("recovery source not taken");
	a_enable_gate: assert property (
		$rose(recoveryActive) |-> $past(sh.ctl[CTL_WD_ENABLE]) || $past(sh.ctl[CTL_WD_ENABLE], 2)
	) else $error("expiry while watchdog disabled");
	a_flag_clear: assert property (
		regWrEn && regAddr == ADDR_CONTROL && regWrData[CTL_EXPIRED] |-> ##[1:2] !recoveryActive
	) else $error("expired flag not cleared");
endmodule
bind freq_select_watchdog_recovery freq_watchdog_asserts #(.RESET_CYC(RESET_CYC)) chk (
	.core_clk(core_clk), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
	.outProgrammed(outProgrammed), .outFreqCode(outFreqCode), .outNumerator(outNumerator),
	.outDenominator(outDenominator), .freqLoad(freqLoad), .recoveryActive(recoveryActive), .sysReset(sysReset));
`default_nettype wire

/* testbench/smbus_host_model.sv */
// firmware host model writing and reading register bytes
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
	// clock
	input  wire logic       core_clk,
	// register byte port
	output var  logic       regWrEn,
	output var  logic [7:0] regAddr,
	output var  logic [7:0] regWrData,
	input  wire logic [7:0] regRdData
);
	initial begin
		regWrEn = 1'b0;
		regAddr = 8'hff;
		regWrData = 8'h00;
	end
	// released data shows the inverse of the last byte
	task automatic put(input logic [7:0] a, input logic [7:0] d, input bit last);
		@(posedge core_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		if (last) begin
			@(posedge core_clk);
			regWrEn <= 1'b0;
			regWrData <= ~d;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		put(a, d, 1'b1);
	endtask
	// both bytes of a pair in one burst, strobe held across
	task automatic wrPair(input logic [7:0] a, input logic [7:0] n, input logic [7:0] m);
		put(a, n, 1'b0);
		put(a + 8'h01, m, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		repeat (2) @(posedge core_clk);
		d = regRdData;
	endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for frequency select and watchdog recovery
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module tb_top;
	import freq_watchdog_pkg::*;
	localparam logic [23:0] SE = 24'h000004;
	localparam logic [23:0] LE = 24'h000008;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        refClkPin = 1'b0;
	logic [4:0]  straps, lat, code;
	logic        regWrEn, outProgrammed, freqLoad, recoveryActive, sysReset, sawReset;
	logic [7:0]  regAddr, regWrData, regRdData, rd, n, rn;
	logic [6:0]  m, rm, outDenominator;
	logic [7:0]  outNumerator;
	logic [4:0]  outFreqCode;
	logic [7:0]  ctl;
	logic [31:0] seed;
	int          fails = 0, samples_checked = 0, dt, lo;
	realtime     t0;

	always #4 core_clk = ~core_clk;
	always #80 refClkPin = ~refClkPin;

	smbus_host_model host (.core_clk(core_clk), .regWrEn(regWrEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData));
	freq_select_watchdog_recovery #(.SHORT_EDGES(SE), .LONG_EDGES(LE), .RESET_CYC(8'h04)) uut (
		.core_clk(core_clk), .rst(rst), .strapFreqInputs(straps), .refClkPin(refClkPin),
		.regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.outProgrammed(outProgrammed), .outFreqCode(outFreqCode), .outNumerator(outNumerator),
		.outDenominator(outDenominator), .freqLoad(freqLoad), .recoveryActive(recoveryActive),
		.sysReset(sysReset));

	// ------------------------------------------
	// helpers
	// ------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int wdCycles(input int load, input logic scale);
		return ((load == 0) ? 32 : load) * int'(scale ? LE : SE) * (REF_PERIOD_NS / CORE_PERIOD_NS);
	endfunction
	task automatic final_report();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// sel 0 waits for a load pulse, sel 1 for recovery
	task automatic waitFor(input bit sel, input int lim);
		int i;
		i = 0;
		while ((sel ? recoveryActive : freqLoad) !== 1'b1 && i < lim) begin
			@(posedge core_clk);
			i++;
		end
		if (i >= lim) begin
			fails++;
			final_report();
		end
		sawReset = sysReset;
		dt = int'(($realtime - t0) / CORE_PERIOD_NS);
		t0 = $realtime;
		repeat (3) @(posedge core_clk);
	endtask
	// window covers the partial first ref period and the edge synchroniser, not a whole tick
	task automatic chkTime(input int exp);
		lo = exp - 2 * (REF_PERIOD_NS / CORE_PERIOD_NS);
		`CHK(dt >= lo && dt <= exp + REF_PERIOD_NS / CORE_PERIOD_NS, 1'b1)
	endtask

	initial begin
		seed = 32'hdc88f68e;
		straps = 5'(rnd());
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		repeat (6) @(posedge core_clk);
		lat = straps;
		`CHK(outFreqCode, lat)
		`CHK(outProgrammed, 1'b0)
		host.rd(ADDR_CONTROL, rd);
		`CHK(rd[7:6], 2'b00)
		straps <= ~lat;
		host.rd(ADDR_STATUS, rd);
		`CHK(rd[7], 1'b1)
		`CHK(rd[4:0], lat)
		host.rd(8'h20, rd);
		`CHK(rd, 8'h00)
		code = 5'(rnd());
		host.wr(ADDR_FREQ_CODE, {3'b000, code});
		host.wr(ADDR_CONTROL, 8'h40);
		repeat (4) @(posedge core_clk);
		`CHK(outFreqCode, code)
		// programmed pairs: range corners, then random
		for (int k = 0; k < 6; k++) begin
			n = (k == 0) ? 8'd97 : (k == 1) ? 8'd245 : 8'(rnd());
			m = (k == 0) ? 7'd93 : (k == 1) ? 7'd45 : 7'(rnd());
			ctl = {1'b1, k[0], 4'b0000, k[1], 1'b0};
			host.wr(ADDR_CONTROL, ctl);
			repeat (8) @(posedge core_clk);
			host.wrPair(ADDR_CPU_NUM, n, {1'b0, m});
			waitFor(1'b0, 20);
			`CHK(sawReset, ctl[1])
			`CHK(outProgrammed, 1'b1)
			`CHK({outNumerator, outDenominator}, {n, m})
			`CHK(outFreqCode, ctl[6] ? code : lat)
			host.rd(ADDR_CPU_DEN, rd);
			`CHK(rd[6:0], m)
		end
		// short tick, straps as recovery, reset on expiry
		host.wr(ADDR_WD_LOAD, 8'h05);
		host.rd(ADDR_WD_LOAD, rd);
		`CHK(rd[4:0], 5'h05)
		host.wr(ADDR_CONTROL, 8'h84);
		repeat (8) @(posedge core_clk);
		host.wr(ADDR_CONTROL, 8'h94);
		host.wrPair(ADDR_CPU_NUM, 8'(rnd()), 8'h10);
		waitFor(1'b0, 20);
		host.rd(ADDR_STATUS, rd);
		`CHK(rd[STS_COUNTING], 1'b1)
		waitFor(1'b1, 2000);
		chkTime(wdCycles(5, 1'b0));
		`CHK(sawReset, 1'b1)
		repeat (4) @(posedge core_clk);
		`CHK({outProgrammed, outFreqCode}, {1'b0, lat})
		host.wr(ADDR_CONTROL, 8'h94);
		host.rd(ADDR_CONTROL, rd);
		`CHK({rd[CTL_EXPIRED], recoveryActive}, 2'b11)
		host.wr(ADDR_CONTROL, 8'h85);
		repeat (4) @(posedge core_clk);
		`CHK(recoveryActive, 1'b0)
		// long tick, recovery pair with software ratio
		rn = 8'(rnd());
		rm = 7'(rnd());
		host.wrPair(ADDR_RCV_NUM, rn, {1'b0, rm});
		host.wr(ADDR_WD_LOAD, 8'h01);
		host.wr(ADDR_CONTROL, 8'he8);
		repeat (8) @(posedge core_clk);
		// the count only starts with a frequency change made while armed
		host.wr(ADDR_CONTROL, 8'hf8);
		host.wrPair(ADDR_CPU_NUM, 8'(rnd()), 8'h10);
		waitFor(1'b0, 20);
		waitFor(1'b1, 2000);
		chkTime(wdCycles(1, 1'b1));
		`CHK(sawReset, 1'b0)
		repeat (4) @(posedge core_clk);
		`CHK({outProgrammed, outNumerator, outDenominator}, {1'b1, rn, rm})
		`CHK(outFreqCode, code)
		rn = ~rn;
		host.wrPair(ADDR_RCV_NUM, rn, {1'b0, rm});
		waitFor(1'b0, 20);
		repeat (2) @(posedge core_clk);
		`CHK(outNumerator, rn)
		// stop before expiry
		host.wr(ADDR_CONTROL, 8'h81);
		repeat (8) @(posedge core_clk);
		host.wr(ADDR_CONTROL, 8'h90);
		host.wrPair(ADDR_CPU_NUM, 8'(rnd()), 8'h20);
		waitFor(1'b0, 20);
		host.wr(ADDR_CONTROL, 8'h80);
		repeat (600) @(posedge core_clk);
		`CHK(recoveryActive, 1'b0)
		final_report();
	end
endmodule
`default_nettype wire
